// ---- design/mcst_top.sv ----
// cassette transfer control, size codes, integrity flags and clock readout with APB slave
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// What this block does
// R01: request bit 00 copies internal program to cassette, cleared by hardware after.
// R02: request bit 01 copies cassette into internal memory, cleared by hardware after.
// R03: request bit 02 compares internal and cassette contents, cleared by hardware after.
// R04: result bit 03 is one on difference or impossible compare, else zero.
// R05: error bit 12 set when transfer refused in programming state.
// R06: error bit 13 set when destination is write-protected.
// R07: error bit 14 set when destination lacks capacity.
// R08: error bit 15 set when cassette holds no program.
// R09: low size byte gives cassette program code, 00 when none or absent.
// R10: high size byte gives internal program code, same codes, never 00.
// R11: setup checksum failure restores defaults and sets flag bit 11.
// R12: program checksum failure or bad instruction sets flag bit 12.
// R13: instruction table checksum failure restores table and sets flag bit 13.
// R14: cassette inserted while powered sets flag bit 14.
// R15: failed automatic power-up load sets flag bit 15.
// R16: time words: seconds/minutes and minutes/hour, BCD, valid only with clock cassette.
// R17: cassette status bit 01 shows a clock-equipped cassette.
// R18: result and error bits settle before the request bit clears.
module mcst_top #(
	parameter logic [15:0] INT_CAP_WORDS = 16'h3b60
) (
	// clock and reset
	input  wire logic                       core_clk_in,
	input  wire logic                       resetn_in,
	// apb slave
	input  wire logic                       psel_in,
	input  wire logic                       penable_in,
	input  wire logic                       pwrite_in,
	input  wire logic [mcst_pkg::APB_AW-1:0] paddr_in,
	input  wire logic [31:0]                pwdata_in,
	output logic      [31:0]                prdata_out,
	output logic                            pready_out,
	output logic                            pslverr_out,
	output logic                            irq_out,
	// controller state
	input  wire logic                       program_mode_in,
	input  wire logic                       autoload_sel_in,
	input  wire logic                       int_wprot_in,
	input  wire logic [15:0]                int_prog_words_in,
	// cassette state
	input  wire logic                       cass_present_in,
	input  wire logic                       cass_wprot_in,
	input  wire logic [15:0]                cass_prog_words_in,
	input  wire logic [15:0]                cass_cap_words_in,
	input  wire mcst_pkg::mcst_time_t       cass_time_in,
	// integrity events
	input  wire logic                       setup_csum_err_in,
	input  wire logic                       prog_invalid_in,
	input  wire logic                       itable_csum_err_in,
	output logic                            setup_restore_out,
	output logic                            itable_restore_out,
	// memory ports
	input  wire logic [15:0]                int_rdata_in,
	input  wire logic [15:0]                cass_rdata_in,
	output mcst_pkg::mcst_mem_req_t         int_req_out,
	output mcst_pkg::mcst_mem_req_t         cass_req_out
);

	typedef enum logic [1:0] {
		CT_IDLE  = 2'b00,
		CT_RUN   = 2'b01,
		CT_CLEAR = 2'b10
	} mcst_ct_st_t;

	// size code from a word count
	function automatic logic [7:0] size_code(input logic [15:0] words);
		if (words == 16'h0000)                 size_code = mcst_pkg::CODE_NONE;
		else if (words < mcst_pkg::SIZE_LIM_1) size_code = mcst_pkg::CODE_1;
		else if (words < mcst_pkg::SIZE_LIM_2) size_code = mcst_pkg::CODE_2;
		else if (words < mcst_pkg::SIZE_LIM_3) size_code = mcst_pkg::CODE_3;
		else                                   size_code = mcst_pkg::CODE_4;
	endfunction

	// byte address of a register index
	function automatic logic [7:0] byte_addr(input logic [7:0] idx);
		byte_addr = {idx[5:0], 2'b00};
	endfunction

	mcst_ct_st_t         st_q, st_d;
	mcst_pkg::mcst_op_t  cur_op_q;
	logic [2:0]          req_q;
	logic                result_q, cur_auto_q, boot_pend_q, cass_prev_q;
	logic [3:0]          err_q;
	logic [15:11]        flags_q;
	logic [mcst_pkg::IRQ_W-1:0] irq_stat_q, irq_mask_q;
	logic [31:0]         prdata_q;
	logic                setup_rst_q, itab_rst_q;
	mcst_pkg::mcst_time_t time_q;
	logic                eng_busy, eng_done, eng_mism;

	////////////////////////////////////////////////////////////////////////////
	// apb decode
	wire acc_w     = psel_in & penable_in;
	wire wr_w      = acc_w & pwrite_in;
	wire setup_w   = psel_in & ~penable_in;
	wire hit_cst   = (paddr_in == byte_addr(mcst_pkg::IDX_CASS_STATUS));
	wire hit_ctrl  = (paddr_in == byte_addr(mcst_pkg::IDX_CTRL));
	wire hit_size  = (paddr_in == byte_addr(mcst_pkg::IDX_SIZE));
	wire hit_flags = (paddr_in == byte_addr(mcst_pkg::IDX_FLAGS));
	wire hit_mh    = (paddr_in == byte_addr(mcst_pkg::IDX_MIN_HOUR));
	wire hit_sm    = (paddr_in == byte_addr(mcst_pkg::IDX_SEC_MIN));
	wire hit_ist   = (paddr_in == byte_addr(mcst_pkg::IDX_IRQ_STATUS));
	wire hit_imk   = (paddr_in == byte_addr(mcst_pkg::IDX_IRQ_MASK));
	wire hit_any   = hit_cst | hit_ctrl | hit_size | hit_flags | hit_mh | hit_sm |
		hit_ist | hit_imk;
	wire ist_rd_w  = acc_w & ~pwrite_in & hit_ist;

	////////////////////////////////////////////////////////////////////////////
	// read views
	wire [7:0] cass_code_w = cass_present_in ? size_code(cass_prog_words_in)
		: mcst_pkg::CODE_NONE; // R09
	wire [7:0] int_code_w  = (int_prog_words_in == 16'h0000) ? mcst_pkg::CODE_1
		: size_code(int_prog_words_in); // R10
	wire       clk_ok_w    = cass_present_in & cass_time_in.valid; // R17
	wire [15:0] cst_w   = {13'h0000, cass_wprot_in, clk_ok_w, cass_present_in};
	wire [15:0] ctrl_w  = {err_q, 8'h00, result_q, req_q};
	wire [15:0] size_w  = {int_code_w, cass_code_w};
	wire [15:0] flags_w = {flags_q, 11'h000};
	wire [15:0] mh_w    = time_q.valid ? {time_q.hour, time_q.minute} : 16'h0000; // R16
	wire [15:0] sm_w    = time_q.valid ? {time_q.minute, time_q.second} : 16'h0000; // R16
	wire [15:0] rd_w    = hit_cst ? cst_w : hit_ctrl ? ctrl_w : hit_size ? size_w :
		hit_flags ? flags_w : hit_mh ? mh_w : hit_sm ? sm_w :
		hit_ist ? {12'h000, irq_stat_q} : hit_imk ? {12'h000, irq_mask_q} : 16'h0000;

	////////////////////////////////////////////////////////////////////////////
	// launch checks
	wire auto_go_w  = boot_pend_q & autoload_sel_in;
	wire launch_w   = (st_q == CT_IDLE) & (auto_go_w | (|req_q));
	wire mcst_pkg::mcst_op_t sel_op_w = (auto_go_w | ~req_q[mcst_pkg::CTRL_TO_CASS]) ?
		((auto_go_w | req_q[mcst_pkg::CTRL_FROM_CASS]) ? mcst_pkg::MCST_OP_FROM_CASS
		: mcst_pkg::MCST_OP_COMPARE) : mcst_pkg::MCST_OP_TO_CASS;
	wire op_to_w    = (sel_op_w == mcst_pkg::MCST_OP_TO_CASS);
	wire op_from_w  = (sel_op_w == mcst_pkg::MCST_OP_FROM_CASS);
	wire op_cmp_w   = (sel_op_w == mcst_pkg::MCST_OP_COMPARE);
	wire no_prog_w  = (cass_code_w == mcst_pkg::CODE_NONE);
	wire pm_fail_w  = ~op_cmp_w & ~auto_go_w & program_mode_in; // R05
	wire wp_fail_w  = (op_to_w & (cass_wprot_in | ~cass_present_in)) |
		(op_from_w & int_wprot_in); // R06
	wire [15:0] cass_cap_w = cass_present_in ? cass_cap_words_in : 16'h0000;
	wire cap_fail_w = (op_to_w & (int_prog_words_in > cass_cap_w)) |
		(op_from_w & (cass_prog_words_in > INT_CAP_WORDS)); // R07
	wire np_fail_w  = op_from_w & no_prog_w; // R08
	wire [3:0] err_vec_w = {np_fail_w, cap_fail_w, wp_fail_w, pm_fail_w};
	wire refuse_w   = (|err_vec_w) | (op_cmp_w & no_prog_w);
	wire eng_start_w = launch_w & ~refuse_w;
	wire [15:0] len_w = op_to_w ? int_prog_words_in : cass_prog_words_in;
	wire auto_fail_w = (launch_w & auto_go_w & refuse_w) |
		((st_q == CT_RUN) & cur_auto_q & eng_done & eng_mism);
	wire added_w    = ~boot_pend_q & cass_present_in & ~cass_prev_q;

	mcst_engine u_engine (
		.clk_in        (core_clk_in),
		.resetn_in     (resetn_in),
		.start_in      (eng_start_w),
		.op_in         (sel_op_w),
		.len_in        (len_w),
		.int_rdata_in  (int_rdata_in),
		.cass_rdata_in (cass_rdata_in),
		.int_req_out   (int_req_out),
		.cass_req_out  (cass_req_out),
		.busy_out      (eng_busy),
		.done_out      (eng_done),
		.mismatch_out  (eng_mism)
	);

	////////////////////////////////////////////////////////////////////////////
	// sequencer
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			CT_IDLE:  if (launch_w) st_d = refuse_w ? CT_CLEAR : CT_RUN;
			CT_RUN:   if (eng_done) st_d = CT_CLEAR;
			CT_CLEAR: st_d = CT_IDLE;
			default:  st_d = CT_IDLE;
		endcase
	end

	wire [mcst_pkg::IRQ_W-1:0] irq_ev_w = {added_w,
		setup_csum_err_in | prog_invalid_in | itable_csum_err_in | auto_fail_w,
		launch_w & refuse_w, st_q == CT_CLEAR};
	wire [2:0] clr_mask_w = (st_q == CT_CLEAR) ? (3'b001 << cur_op_q) : 3'b000;
	wire [2:0] req_set_w  = (wr_w & hit_ctrl & (st_q == CT_IDLE)) ? pwdata_in[2:0] : 3'b000;

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_q        <= CT_IDLE;
			cur_op_q    <= mcst_pkg::MCST_OP_TO_CASS;
			cur_auto_q  <= 1'b0;
			req_q       <= 3'b000;
			result_q    <= 1'b0;
			err_q       <= 4'h0;
			boot_pend_q <= 1'b1;
			cass_prev_q <= 1'b0;
		end else begin
			st_q        <= st_d;
			boot_pend_q <= 1'b0;
			cass_prev_q <= cass_present_in;
			req_q       <= (req_q & ~clr_mask_w) | req_set_w; // R01 R02 R03 R18
			if (launch_w) begin
				cur_op_q   <= sel_op_w;
				cur_auto_q <= auto_go_w;
				err_q      <= err_vec_w; // R05 R06 R07 R08
				result_q   <= op_cmp_w & no_prog_w; // R04
			end
			if (st_q == CT_RUN && eng_done && cur_op_q == mcst_pkg::MCST_OP_COMPARE)
				result_q <= eng_mism; // R04 R18
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// integrity flags, interrupts, time capture, apb data
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			flags_q     <= 5'h00;
			setup_rst_q <= 1'b0;
			itab_rst_q  <= 1'b0;
			irq_stat_q  <= 4'h0;
			irq_mask_q  <= 4'h0;
			time_q      <= '0;
			prdata_q    <= 32'h0000_0000;
		end else begin
			flags_q     <= flags_q | {auto_fail_w, added_w, itable_csum_err_in,
				prog_invalid_in, setup_csum_err_in}; // R11 R12 R13 R14 R15
			setup_rst_q <= setup_csum_err_in; // R11
			itab_rst_q  <= itable_csum_err_in; // R13
			irq_stat_q  <= (irq_stat_q & ~{mcst_pkg::IRQ_W{ist_rd_w}}) | irq_ev_w;
			if (wr_w && hit_imk)
				irq_mask_q <= pwdata_in[mcst_pkg::IRQ_W-1:0];
			time_q      <= cass_time_in;
			time_q.valid <= clk_ok_w; // R16
			if (setup_w)
				prdata_q <= {16'h0000, rd_w};
		end
	end

	assign prdata_out         = prdata_q;
	assign pready_out         = 1'b1;
	assign pslverr_out        = acc_w & ~hit_any;
	assign irq_out            = |(irq_stat_q & irq_mask_q);
	assign setup_restore_out  = setup_rst_q;
	assign itable_restore_out = itab_rst_q;

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);

	a_to_cass_clear: assert property ( // R01
		st_q == CT_CLEAR && cur_op_q == mcst_pkg::MCST_OP_TO_CASS |=>
		!req_q[mcst_pkg::CTRL_TO_CASS] && st_q == CT_IDLE)
		else $error("copy-out request not cleared");
	a_from_cass_run: assert property ( // R02
		eng_start_w && op_from_w |=> eng_busy && st_q == CT_RUN)
		else $error("copy-in did not start");
	a_from_cass_clear: assert property ( // R02
		st_q == CT_RUN && eng_done && cur_op_q == mcst_pkg::MCST_OP_FROM_CASS |=>
		st_q == CT_CLEAR ##1 !req_q[mcst_pkg::CTRL_FROM_CASS])
		else $error("copy-in request not cleared");
	a_to_cass_run: assert property ( // R01
		eng_start_w && op_to_w |=> eng_busy || eng_done)
		else $error("copy-out did not start");
	a_cmp_clear: assert property ( // R03
		st_q == CT_CLEAR && cur_op_q == mcst_pkg::MCST_OP_COMPARE |=>
		!req_q[mcst_pkg::CTRL_COMPARE])
		else $error("compare request not cleared");
	a_cmp_result: assert property ( // R04
		st_q == CT_RUN && eng_done && cur_op_q == mcst_pkg::MCST_OP_COMPARE |=>
		result_q == $past(eng_mism) ##1 !req_q[mcst_pkg::CTRL_COMPARE])
		else $error("compare result wrong");
	a_pmode_err: assert property ( // R05
		launch_w && program_mode_in && !op_cmp_w && !auto_go_w |=>
		err_q[0] && st_q == CT_CLEAR)
		else $error("program mode error missing");
	a_wprot_err: assert property ( // R06
		launch_w && op_to_w && cass_wprot_in |=> err_q[1] && !eng_busy)
		else $error("write-protect error missing");
	a_cap_err: assert property ( // R07
		launch_w && op_from_w && cass_prog_words_in > INT_CAP_WORDS |=> err_q[2])
		else $error("capacity error missing");
	a_noprog_err: assert property ( // R08
		launch_w && op_from_w && no_prog_w |=> err_q[3] ##1 st_q == CT_IDLE)
		else $error("no program error missing");
	a_setup_init: assert property ( // R11
		setup_csum_err_in |=> setup_restore_out && flags_q[mcst_pkg::FLAG_SETUP_INIT])
		else $error("setup init flag missing");
	a_cass_added: assert property ( // R14
		!boot_pend_q && $rose(cass_present_in) |=> flags_q[mcst_pkg::FLAG_CASS_ADDED]
		&& irq_stat_q[mcst_pkg::IRQ_ADDED])
		else $error("cassette added flag missing");
	a_req_order: assert property ( // R18
		$fell(req_q[mcst_pkg::CTRL_COMPARE]) |-> $past(st_q) == CT_CLEAR)
		else $error("request cleared before status");
	a_wp_in_err: assert property ( // R06
		launch_w && op_from_w && int_wprot_in |=> err_q[1])
		else $error("internal write-protect error missing");
	a_cmp_noprog: assert property ( // R04
		launch_w && op_cmp_w && no_prog_w |=>
		result_q && st_q == CT_CLEAR)
		else $error("impossible compare not flagged");
	a_err_hold: assert property ( // R18
		st_q != CT_IDLE |=> $stable(err_q))
		else $error("error bits changed during operation");

	// integrity flags and read views
	a_prog_bad: assert property ( // R12
		prog_invalid_in |=> flags_q[mcst_pkg::FLAG_PROG_BAD])
		else $error("program invalid flag missing");
	a_itab_init: assert property ( // R13
		itable_csum_err_in |=>
		itable_restore_out && flags_q[mcst_pkg::FLAG_ITAB_INIT])
		else $error("table init flag missing");
	a_auto_fail: assert property ( // R15
		auto_fail_w |=> flags_q[mcst_pkg::FLAG_AUTO_FAIL])
		else $error("autoload failure flag missing");
	a_cass_code: assert property ( // R09
		cass_present_in && cass_prog_words_in != 16'h0000 |->
		cass_code_w != mcst_pkg::CODE_NONE)
		else $error("cassette size code missing");
	a_int_code: assert property ( // R10
		int_code_w != mcst_pkg::CODE_NONE)
		else $error("internal size code zero");
	a_clock_bit: assert property ( // R17
		!cass_present_in |-> !cst_w[mcst_pkg::CST_CLOCK])
		else $error("clock bit without cassette");
	a_time_capt: assert property ( // R16
		clk_ok_w |=> time_q.valid &&
		mh_w == {$past(cass_time_in.hour), $past(cass_time_in.minute)})
		else $error("time word wrong");


	c_cmp_mism: cover property (st_q == CT_RUN && eng_done && eng_mism);
	c_refused:  cover property (launch_w && refuse_w);
	c_irq:      cover property ($rose(irq_out));
	c_autoload: cover property (launch_w && auto_go_w);
	c_copy_in:  cover property (eng_start_w && op_from_w);

endmodule
`default_nettype wire

// ---- design/mcst_pkg.sv ----
// package: register map, field positions, size codes and carriers for cassette transfer
package mcst_pkg;

	localparam int unsigned APB_AW = 8;
	localparam int unsigned MEM_AW = 16;
	localparam int unsigned MEM_DW = 16;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_CASS_STATUS = 8'h0d;
	localparam logic [7:0] IDX_CTRL        = 8'h0e;
	localparam logic [7:0] IDX_SIZE        = 8'h0f;
	localparam logic [7:0] IDX_FLAGS       = 8'h10;
	localparam logic [7:0] IDX_MIN_HOUR    = 8'h11;
	localparam logic [7:0] IDX_SEC_MIN     = 8'h12;
	localparam logic [7:0] IDX_IRQ_STATUS  = 8'h20;
	localparam logic [7:0] IDX_IRQ_MASK    = 8'h21;

	// transfer control word fields
	localparam int CTRL_TO_CASS   = 0;
	localparam int CTRL_FROM_CASS = 1;
	localparam int CTRL_COMPARE   = 2;
	localparam int CTRL_RESULT    = 3;
	localparam int CTRL_ERR_LO    = 12;

	// system flag word fields
	localparam int FLAG_SETUP_INIT = 11;
	localparam int FLAG_PROG_BAD   = 12;
	localparam int FLAG_ITAB_INIT  = 13;
	localparam int FLAG_CASS_ADDED = 14;
	localparam int FLAG_AUTO_FAIL  = 15;

	// cassette status word fields
	localparam int CST_PRESENT = 0;
	localparam int CST_CLOCK   = 1;
	localparam int CST_WPROT   = 2;

	// interrupt status fields
	localparam int IRQ_W     = 4;
	localparam int IRQ_DONE  = 0;
	localparam int IRQ_ERR   = 1;
	localparam int IRQ_FLAG  = 2;
	localparam int IRQ_ADDED = 3;

	// program size limits in words and their codes
	localparam logic [15:0] SIZE_LIM_1 = 16'h0c80;
	localparam logic [15:0] SIZE_LIM_2 = 16'h1c20;
	localparam logic [15:0] SIZE_LIM_3 = 16'h2bc0;
	localparam logic [15:0] SIZE_LIM_4 = 16'h3b60;
	localparam logic [7:0]  CODE_NONE  = 8'h00;
	localparam logic [7:0]  CODE_1     = 8'h04;
	localparam logic [7:0]  CODE_2     = 8'h08;
	localparam logic [7:0]  CODE_3     = 8'h12;
	localparam logic [7:0]  CODE_4     = 8'h16;

	typedef enum logic [1:0] {
		MCST_OP_TO_CASS   = 2'b00,
		MCST_OP_FROM_CASS = 2'b01,
		MCST_OP_COMPARE   = 2'b10
	} mcst_op_t;

	typedef struct packed {
		logic [MEM_AW-1:0] addr;
		logic              we;
		logic [MEM_DW-1:0] wdata;
	} mcst_mem_req_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] hour;
		logic [7:0] minute;
		logic [7:0] second;
	} mcst_time_t;

endpackage

// ---- design/mcst_engine.sv ----
// word-by-word copy and compare engine between internal memory and cassette
`timescale 1ns/10ps
`default_nettype none

module mcst_engine (
	// clock and reset
	input  wire logic                  clk_in,
	input  wire logic                  resetn_in,
	// command
	input  wire logic                  start_in,
	input  wire mcst_pkg::mcst_op_t    op_in,
	input  wire logic [15:0]           len_in,
	// memories, one cycle read latency
	input  wire logic [15:0]           int_rdata_in,
	input  wire logic [15:0]           cass_rdata_in,
	output mcst_pkg::mcst_mem_req_t    int_req_out,
	output mcst_pkg::mcst_mem_req_t    cass_req_out,
	// status
	output logic                       busy_out,
	output logic                       done_out,
	output logic                       mismatch_out
);

	typedef enum logic [1:0] {
		ENG_IDLE  = 2'b00,
		ENG_READ  = 2'b01,
		ENG_CAPT  = 2'b10,
		ENG_WRITE = 2'b11
	} mcst_eng_st_t;

	mcst_eng_st_t        st_q, st_d;
	mcst_pkg::mcst_op_t  op_q;
	logic [15:0]         idx_q, len_q, data_q;
	logic                mism_q, done_q;

	wire last_w   = (idx_q == (len_q - 16'h0001));
	wire is_cmp_w = (op_q == mcst_pkg::MCST_OP_COMPARE);
	wire differ_w = (int_rdata_in != cass_rdata_in);

	always_comb begin
		st_d = st_q;
		unique case (st_q)
			ENG_IDLE:  if (start_in && len_in != 16'h0000) st_d = ENG_READ;
			ENG_READ:  st_d = ENG_CAPT;
			ENG_CAPT:  st_d = is_cmp_w ? (last_w ? ENG_IDLE : ENG_READ) : ENG_WRITE;
			ENG_WRITE: st_d = last_w ? ENG_IDLE : ENG_READ;
		endcase
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_q   <= ENG_IDLE;
			op_q   <= mcst_pkg::MCST_OP_TO_CASS;
			idx_q  <= 16'h0000;
			len_q  <= 16'h0000;
			data_q <= 16'h0000;
			mism_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			st_q   <= st_d;
			done_q <= (st_q == ENG_IDLE && start_in && len_in == 16'h0000) ||
				(st_q != ENG_IDLE && st_d == ENG_IDLE);
			if (st_q == ENG_IDLE && start_in) begin
				op_q   <= op_in;
				len_q  <= len_in;
				idx_q  <= 16'h0000;
				mism_q <= 1'b0;
			end
			if (st_q == ENG_CAPT) begin
				data_q <= (op_q == mcst_pkg::MCST_OP_TO_CASS) ? int_rdata_in : cass_rdata_in;
				mism_q <= mism_q | (is_cmp_w & differ_w);
			end
			if (st_d == ENG_READ && st_q != ENG_IDLE)
				idx_q <= idx_q + 16'h0001;
		end
	end

	// destination write strobes
	assign int_req_out  = '{addr: idx_q, wdata: data_q,
		we: (st_q == ENG_WRITE) && (op_q == mcst_pkg::MCST_OP_FROM_CASS)};
	assign cass_req_out = '{addr: idx_q, wdata: data_q,
		we: (st_q == ENG_WRITE) && (op_q == mcst_pkg::MCST_OP_TO_CASS)};
	assign busy_out     = (st_q != ENG_IDLE);
	assign done_out     = done_q;
	assign mismatch_out = mism_q;

endmodule
`default_nettype wire

// ---- testbench/mcst_cass_model.sv ----
// cassette model: word memory with one-cycle read latency
`timescale 1ns/10ps
`default_nettype none

module mcst_cass_model (
	// clock
	input  wire logic                    clk_in,
	// cassette side
	input  wire logic                    present_in,
	input  wire mcst_pkg::mcst_mem_req_t req_in,
	output logic [15:0]                  rdata_out
);
	logic [15:0] mem [0:63];
	logic [15:0] last_q;

	initial last_q = 16'h0000;

	////////////////////////////////////////////////////////////////////////////////
	// absent cassette drives a changing pattern, never the last word
	always @(posedge clk_in) begin
		if (req_in.we && present_in)
			mem[req_in.addr[5:0]] <= req_in.wdata;
		last_q <= present_in ? mem[req_in.addr[5:0]] : ~last_q;
	end

	assign rdata_out = last_q;
endmodule

`default_nettype wire

// ---- testbench/memory_cassette_transfer_status_bench.sv ----
// self-checking bench: apb driver, expectation queue, monitor, internal memory
`timescale 1ns/10ps
`default_nettype none

module memory_cassette_transfer_status_bench;
	logic                    clk, rstn, psel, penable, pwrite, pready, pslverr, irq;
	logic [7:0]              paddr;
	logic [31:0]             pwdata, prdata;
	logic                    pmode, asel, iwp, cpres, cwp, srest, irest;
	logic [15:0]             iwords, cwords, ccap, irdata, crdata;
	logic [2:0]              ev;
	mcst_pkg::mcst_time_t    tm;
	mcst_pkg::mcst_mem_req_t ireq, creq;
	logic [15:0]             imem [0:63];
	logic [64:0]             exp_q [$];
	logic [64:0]             ent;
	int                      fails, checked, seed;
	logic [15:0]             lim [4] = '{mcst_pkg::SIZE_LIM_1, mcst_pkg::SIZE_LIM_2,
		mcst_pkg::SIZE_LIM_3, mcst_pkg::SIZE_LIM_4};
	logic [7:0]              cd [4] = '{mcst_pkg::CODE_1, mcst_pkg::CODE_2,
		mcst_pkg::CODE_3, mcst_pkg::CODE_4};

	mcst_top dut (
		.core_clk_in(clk), .resetn_in(rstn), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .irq_out(irq),
		.program_mode_in(pmode), .autoload_sel_in(asel), .int_wprot_in(iwp),
		.int_prog_words_in(iwords), .cass_present_in(cpres), .cass_wprot_in(cwp),
		.cass_prog_words_in(cwords), .cass_cap_words_in(ccap), .cass_time_in(tm),
		.setup_csum_err_in(ev[0]), .prog_invalid_in(ev[1]), .itable_csum_err_in(ev[2]),
		.setup_restore_out(srest), .itable_restore_out(irest),
		.int_rdata_in(irdata), .cass_rdata_in(crdata), .int_req_out(ireq), .cass_req_out(creq)
	);

	mcst_cass_model cas (.clk_in(clk), .present_in(cpres), .req_in(creq), .rdata_out(crdata));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		irdata <= imem[ireq.addr[5:0]];
		if (ireq.we)
			imem[ireq.addr[5:0]] <= ireq.wdata;
	end

	////////////////////////////////////////////////////////////////////////////////
	// checking and closing
	task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
		checked++;
		if (seen !== want) begin
			fails++;
			$display("[FAIL] %0t %s: saw %h want %h", $time, what, seen, want);
		end
	endtask

	task automatic stop_test();
		if (fails == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic expire();
		fails++;
		stop_test();
	endtask

	// monitor: oldest note against each completed transfer
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1) begin
			ent = exp_q.pop_front();
			check(prdata & ent[63:32], ent[31:0] & ent[63:32], "read data");
			check({31'h0, pslverr}, {31'h0, ent[64]}, "error response");
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// apb master
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			input logic [64:0] e, output logic [31:0] rd);
		int n;
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		exp_q.push_back(e);
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
		if (n >= 50)
			expire();
	endtask

	task automatic rdq(input logic [7:0] a, input logic [31:0] e, input logic se);
		logic [31:0] r;
		apb(1'b0, a, 32'h0, {se, 32'hffff_ffff, e}, r);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, 65'h0, r);
	endtask

	task automatic poll(input logic [7:0] a, input logic [15:0] m, input logic [15:0] v,
			output logic [31:0] r);
		int n;
		n = 0;
		do begin
			apb(1'b0, a, 32'h0, 65'h0, r);
			n++;
		end while ((r[15:0] & m) !== v && n < 100);
		if (n >= 100)
			expire();
	endtask

	task automatic op(input int b, input logic [15:0] e);
		logic [31:0] r;
		wr(8'h38, 32'h1 << b);
		poll(8'h38, 16'h0007, 16'h0000, r);
		check(r & (b == 2 ? 32'h0000_f00f : 32'h0000_f007), {16'h0, e}, "op status");
	endtask

	task automatic see_irq(input logic e);
		#1 check({31'h0, irq}, {31'h0, e}, "interrupt line");
		@(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		logic [31:0] r;
		logic [15:0] v;
		seed = 9;
		fails = 0;
		checked = 0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{pmode, asel, iwp, cpres, cwp, ev} = '0;
		tm = '0;
		iwords = 16'h0000;
		cwords = 16'h0064;
		ccap = 16'h0040;
		for (int i = 0; i < 64; i++) begin
			imem[i] = 16'($random(seed));
			cas.mem[i] = 16'($random(seed));
		end
		rstn = 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rdq(8'h3c, {16'h0, mcst_pkg::CODE_1, mcst_pkg::CODE_NONE}, 1'b0);
		for (int i = 0; i < 3; i++) begin
			ev[i] <= 1'b1;
			@(posedge clk);
			ev[i] <= 1'b0;
			#1 check({30'h0, irest, srest}, {30'h0, i == 2, i == 0}, "restore pulse");
			@(posedge clk);
		end
		see_irq(1'b0);
		wr(8'h84, 32'hffff_fff4);
		see_irq(1'b1);
		rdq(8'h84, 32'h0000_0004, 1'b0);
		rdq(8'h40, 32'h0000_3800, 1'b0);
		rdq(8'h80, 32'h0000_0004, 1'b0);
		see_irq(1'b0);
		cpres <= 1'b1;
		poll(8'h40, 16'h4000, 16'h4000, r);
		check(r, 32'h0000_7800, "flags after insert");
		for (int i = 0; i < 8; i++) begin
			v = 16'($unsigned($random(seed)) % 32'h0000_0c7f + 32'h0000_0001);
			if (i > 1)
				v = v + lim[i / 2 - 1];
			if (i % 2)
				v = lim[i / 2] - 16'h0001;
			iwords <= v;
			cwords <= v;
			@(posedge clk);
			rdq(8'h3c, {16'h0, cd[i / 2], cd[i / 2]}, 1'b0);
		end
		tm <= {1'b1, 8'h23, 8'h59, 8'h07};
		@(posedge clk);
		rdq(8'h48, 32'h0000_5907, 1'b0);
		rdq(8'h44, 32'h0000_2359, 1'b0);
		rdq(8'h34, 32'h0000_0003, 1'b0);
		tm.valid <= 1'b0;
		@(posedge clk);
		rdq(8'h34, 32'h0000_0001, 1'b0);
		iwords <= 16'h0006;
		cwords <= 16'h0006;
		op(0, 16'h0000);
		for (int i = 0; i < 6; i++)
			check({16'h0, cas.mem[i]}, {16'h0, imem[i]}, "cassette word");
		op(2, 16'h0000);
		cas.mem[5] = ~cas.mem[5];
		op(2, 16'h0008);
		for (int i = 0; i < 6; i++)
			cas.mem[i] = 16'($random(seed));
		op(1, 16'h0000);
		for (int i = 0; i < 6; i++)
			check({16'h0, imem[i]}, {16'h0, cas.mem[i]}, "internal word");
		pmode <= 1'b1;
		op(0, 16'h1000);
		op(1, 16'h1000);
		pmode <= 1'b0;
		cwp <= 1'b1;
		op(0, 16'h2000);
		cwp <= 1'b0;
		iwp <= 1'b1;
		op(1, 16'h2000);
		iwp <= 1'b0;
		ccap <= 16'h0003;
		op(0, 16'h4000);
		cwords <= mcst_pkg::SIZE_LIM_4 + 16'h0001;
		op(1, 16'h4000);
		cwords <= 16'h0000;
		op(1, 16'h8000);
		op(2, 16'h0008);
		wr(8'h84, 32'h0000_0003);
		see_irq(1'b1);
		rdq(8'h80, 32'h0000_000b, 1'b0);
		see_irq(1'b0);
		rdq(8'h4c, 32'h0000_0000, 1'b1);
		apb(1'b1, 8'h4c, 32'h0000_0001, {1'b1, 64'h0}, r);
		asel <= 1'b1;
		rstn <= 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		poll(8'h40, 16'h8000, 16'h8000, r);
		check(r, 32'h0000_8000, "flags after failed load");
		stop_test();
	end
endmodule

`default_nettype wire
